// ---- verilog/sound_pkg.sv ----
// Constants shared by the serial sound output block and its FIFO.
package sound_pkg;
   // Register offsets (byte addresses).
   localparam logic [8:0] OFS_DISPLAY_MUX_CONTROL = 9'h06C;
   localparam logic [8:0] OFS_SOUND_DMA_CURRENT_A = 9'h180;
   localparam logic [8:0] OFS_SOUND_DMA_END_A     = 9'h184;
   localparam logic [8:0] OFS_SOUND_DMA_CURRENT_B = 9'h188;
   localparam logic [8:0] OFS_SOUND_DMA_END_B     = 9'h18C;
   localparam logic [8:0] OFS_SOUND_DMA_CONTROL   = 9'h190;
   localparam logic [8:0] OFS_SOUND_DMA_STATE     = 9'h194;
   // Reset values.
   localparam logic [7:0]  RST_REG8  = 8'h00;
   localparam logic [31:0] RST_REG32 = 32'h0000_0000;
   // Field positions.
   localparam int MUX_FMT_BIT     = 0;
   localparam int DMA_CTL_EN_BIT  = 0;
   localparam int SCTL_CLKSEL_BIT = 0;
   localparam int SCTL_RUN_MSB    = 2;
   localparam int SCTL_RUN_LSB    = 1;
   localparam int ST_REQ_BIT      = 3;
   localparam int ST_LATCH_BIT    = 4;
   localparam int ST_RUN_BIT      = 5;
   // Stream framing.
   localparam int          FIFO_WORDS    = 4;
   localparam int          WORD_BITS     = 32;
   localparam logic [1:0]  LAST_BYTE     = 2'h3;
   localparam logic [4:0]  FIRST_BIT     = 5'h00;
   localparam logic [4:0]  LAST_BIT      = 5'h1F;
   localparam logic [4:0]  LEFT_LSB_BIT  = 5'h0F;
   localparam logic [4:0]  RIGHT_ENDWS   = 5'h1E;
   localparam logic [2:0]  BYTE_START    = 3'h0;
   localparam logic [31:0] DMA_ADDR_STEP = 32'h0000_0004;
   // Source ticks per half bit period are the divider value times this factor.
   localparam logic [1:0]  HALF_MULT     = 2'h2;
endpackage : sound_pkg

// ---- verilog/sound_fifo.sv ----
// Small word FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module sound_fifo
   import sound_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
)(
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_rst,
   input  wire logic                       i_wr_valid,
   output logic                            o_wr_ready,
   input  wire logic [WIDTH-1:0]           i_wr_data,
   output logic                            o_rd_valid,
   input  wire logic                       i_rd_ready,
   output logic [WIDTH-1:0]                o_rd_data,
   output logic [$clog2(DEPTH+1)-1:0]      o_level
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int LW = $clog2(DEPTH+1);
   localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);
   localparam logic [AW-1:0] LAST_IDX   = AW'(DEPTH-1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [LW-1:0]    level_q;
   logic             push;
   logic             pop;

   assign o_wr_ready = (level_q != FULL_LEVEL);
   assign o_rd_valid = (level_q != '0);
   assign o_rd_data  = mem_q[rd_ptr_q];
   assign o_level    = level_q;
   assign push       = i_wr_valid && o_wr_ready;
   assign pop        = o_rd_valid && i_rd_ready;

   always_ff @(posedge i_clk_sys)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= i_wr_data;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         level_q  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= (wr_ptr_q == LAST_IDX) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_q <= (rd_ptr_q == LAST_IDX) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop)
         begin
            level_q <= level_q + 1'b1;
         end
         else if (pop && !push)
         begin
            level_q <= level_q - 1'b1;
         end
      end
   end

   fifo_first_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE1]
      push && (level_q == '0) |=> o_rd_data == $past(i_wr_data)) else $error("first word lost");
endmodule : sound_fifo

// ---- verilog/serial_sound_output.sv ----
// Serial sound output: DMA-fed FIFO, byte latch and three-wire stereo link.
//
// Overview of operation
// [RULE1] Four-word FIFO refilled fully by DMA when empty.
// [RULE2] FIFO drains one byte at a time via latch.
// [RULE3] Drive bit clock, data and word-select pins.
// [RULE4] Sound off: clock low, data low, select high.
// [RULE5] Bytes shift out most significant bit first.
// [RULE6] Parallel load, one bit per bit clock.
// [RULE7] Display mux bit 0 picks timing format.
// [RULE8] Normal sample: 16 left then 16 right.
// [RULE9] Normal select toggles at previous word lsb.
// [RULE10] Normal select high for right, low left.
// [RULE11] Alternate select toggles at new word msb.
// [RULE12] Alternate select polarity inverted, high left.
// [RULE13] Data changes after bit clock falling edge.
// [RULE14] External sound clock can source bit rate.
// [RULE15] Software sets enable, clksel 0, divider 2.
// [RULE16] Software programs divider for other clock rates.
// [RULE17] Request holds until four words delivered.
// [RULE18] Nonzero enable runs, restart at left sample.
`timescale 1ns/10ps
module serial_sound_output
   import sound_pkg::*;
#(
   parameter int DIV_W = 8
)(
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst,
   input  wire logic              i_reg_wr,
   input  wire logic              i_reg_rd,
   input  wire logic [8:0]        i_reg_addr,
   input  wire logic [31:0]       i_reg_wdata,
   output logic [31:0]            o_reg_rdata,
   output logic                   o_reg_rvalid,
   input  wire logic [2:0]        i_sound_ctl,
   input  wire logic [DIV_W-1:0]  i_sound_freq,
   input  wire logic              i_ext_sound_clk,
   output logic                   o_dma_req,
   output logic [31:0]            o_dma_addr,
   input  wire logic              i_dma_valid,
   output logic                   o_dma_ready,
   input  wire logic [31:0]       i_dma_data,
   output logic                   o_serial_bit_clock_out,
   output logic                   o_serial_data_out,
   output logic                   o_channel_select_out
);
   localparam int LW = $clog2(FIFO_WORDS+1);
   localparam int CW = DIV_W + 2;

   logic [7:0]   mux_ctl_q;
   logic [31:0]  cur_a_q;
   logic [31:0]  end_a_q;
   logic [31:0]  cur_b_q;
   logic [31:0]  end_b_q;
   logic [7:0]   dma_ctl_q;
   logic [31:0]  rdata_d;
   logic         req_q;
   logic [1:0]   fill_q;
   logic         accept;
   logic         fifo_wr_ready;
   logic         fifo_rd_valid;
   logic         fifo_rd_ready;
   logic [31:0]  fifo_rd_data;
   logic [LW-1:0] fifo_level;
   logic [7:0]   latch_q;
   logic         latch_v_q;
   logic [1:0]   byte_idx_q;
   logic         fill_latch;
   logic         take;
   logic         ext_s1_q;
   logic         ext_s2_q;
   logic         ext_prev_q;
   logic         src_tick;
   logic [CW-1:0] div_cnt_q;
   logic [CW-1:0] half_ticks;
   logic         tick;
   logic         run;
   logic         started_q;
   logic         fall_act;
   logic [4:0]   bit_q;
   logic [4:0]   next_bit;
   logic [7:0]   shreg_q;
   logic [7:0]   load_byte;
   logic         fmt_alt;

   // Register port.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         mux_ctl_q <= RST_REG8;
         end_a_q   <= RST_REG32;
         cur_b_q   <= RST_REG32;
         end_b_q   <= RST_REG32;
         dma_ctl_q <= RST_REG8;
      end
      else if (i_reg_wr)
      begin
         case (i_reg_addr)
            OFS_DISPLAY_MUX_CONTROL: mux_ctl_q <= i_reg_wdata[7:0];
            OFS_SOUND_DMA_END_A:     end_a_q   <= i_reg_wdata;
            OFS_SOUND_DMA_CURRENT_B: cur_b_q   <= i_reg_wdata;
            OFS_SOUND_DMA_END_B:     end_b_q   <= i_reg_wdata;
            OFS_SOUND_DMA_CONTROL:   dma_ctl_q <= i_reg_wdata[7:0];
            default:                 ;
         endcase
      end
   end

   // The current pointer advances one word per delivered word; a software write wins.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         cur_a_q <= RST_REG32;
      end
      else if (i_reg_wr && (i_reg_addr == OFS_SOUND_DMA_CURRENT_A))
      begin
         cur_a_q <= i_reg_wdata;
      end
      else if (accept)
      begin
         cur_a_q <= cur_a_q + DMA_ADDR_STEP;
      end
   end

   always_comb
   begin
      rdata_d = '0;
      case (i_reg_addr)
         OFS_DISPLAY_MUX_CONTROL: rdata_d[7:0] = mux_ctl_q;
         OFS_SOUND_DMA_CURRENT_A: rdata_d = cur_a_q;
         OFS_SOUND_DMA_END_A:     rdata_d = end_a_q;
         OFS_SOUND_DMA_CURRENT_B: rdata_d = cur_b_q;
         OFS_SOUND_DMA_END_B:     rdata_d = end_b_q;
         OFS_SOUND_DMA_CONTROL:   rdata_d[7:0] = dma_ctl_q;
         OFS_SOUND_DMA_STATE:
         begin
            rdata_d[LW-1:0]     = fifo_level;
            rdata_d[ST_REQ_BIT]   = req_q;
            rdata_d[ST_LATCH_BIT] = latch_v_q;
            rdata_d[ST_RUN_BIT]   = run;
         end
         default:                 rdata_d = '0;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_reg_rdata  <= RST_REG32;
         o_reg_rvalid <= 1'b0;
      end
      else
      begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd)
         begin
            o_reg_rdata <= rdata_d;
         end
      end
   end

   // DMA refill: raised only on an empty FIFO, held for exactly four words.
   assign accept      = req_q && i_dma_valid && fifo_wr_ready;
   assign o_dma_ready = req_q && fifo_wr_ready;
   assign o_dma_req   = req_q;
   assign o_dma_addr  = cur_a_q;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         req_q  <= 1'b0;
         fill_q <= '0;
      end
      else if (!req_q && dma_ctl_q[DMA_CTL_EN_BIT] && (fifo_level == '0)) // [RULE1]
      begin
         req_q <= 1'b1;
      end
      else if (accept)
      begin
         fill_q <= fill_q + 1'b1;
         if (fill_q == LAST_BYTE) // [RULE17]
         begin
            req_q <= 1'b0;
         end
      end
   end

   sound_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (FIFO_WORDS)
   ) u_fifo (
      .i_clk_sys  (i_clk_sys),
      .i_rst      (i_rst),
      .i_wr_valid (req_q && i_dma_valid),
      .o_wr_ready (fifo_wr_ready),
      .i_wr_data  (i_dma_data),
      .o_rd_valid (fifo_rd_valid),
      .i_rd_ready (fifo_rd_ready),
      .o_rd_data  (fifo_rd_data),
      .o_level    (fifo_level)
   );

   // Byte latch: low byte of each word first, word popped after its last byte.
   assign fill_latch    = (!latch_v_q || take) && fifo_rd_valid;
   assign fifo_rd_ready = fill_latch && (byte_idx_q == LAST_BYTE); // [RULE2]

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         latch_q    <= '0;
         latch_v_q  <= 1'b0;
         byte_idx_q <= '0;
      end
      else if (fill_latch)
      begin
         latch_q    <= fifo_rd_data[{byte_idx_q, 3'h0} +: 8]; // [RULE2]
         latch_v_q  <= 1'b1;
         byte_idx_q <= byte_idx_q + 1'b1;
      end
      else if (take)
      begin
         latch_v_q <= 1'b0;
      end
   end

   // No reset here: the stages follow the pin, so a high pin gives no false edge at release.
   always_ff @(posedge i_clk_sys)
   begin
      ext_s1_q   <= i_ext_sound_clk;
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
   end

   assign run      = |i_sound_ctl[SCTL_RUN_MSB:SCTL_RUN_LSB]; // [RULE18]
   assign src_tick = i_sound_ctl[SCTL_CLKSEL_BIT] ? 1'b1 : (ext_s2_q && !ext_prev_q); // [RULE14]
   // A zero divider would stop the link, so it behaves as the smallest half period.
   assign half_ticks = (i_sound_freq == '0) ? CW'(1) : CW'(i_sound_freq) * CW'(HALF_MULT);
   assign tick       = run && src_tick && (div_cnt_q >= half_ticks - 1'b1); // [RULE16]

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || !run)
      begin
         div_cnt_q <= '0;
      end
      else if (src_tick)
      begin
         div_cnt_q <= tick ? '0 : div_cnt_q + 1'b1;
      end
   end

   // Serial engine: every data change happens on the falling half of the bit clock.
   assign fmt_alt   = mux_ctl_q[MUX_FMT_BIT]; // [RULE7]
   assign fall_act  = tick && (!started_q || o_serial_bit_clock_out);
   assign next_bit  = bit_q + 1'b1;
   assign take      = fall_act && (next_bit[2:0] == BYTE_START);
   assign load_byte = latch_v_q ? latch_q : 8'h00;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || !run)
      begin
         o_serial_bit_clock_out <= 1'b0; // [RULE4]
         o_serial_data_out      <= 1'b0; // [RULE4]
         o_channel_select_out   <= 1'b1; // [RULE4]
         started_q              <= 1'b0;
         bit_q                  <= LAST_BIT; // [RULE18]
         shreg_q                <= '0;
      end
      else if (fall_act)
      begin
         o_serial_bit_clock_out <= 1'b0; // [RULE13]
         started_q              <= 1'b1;
         bit_q                  <= next_bit; // [RULE8]
         if (take)
         begin
            shreg_q           <= load_byte; // [RULE6]
            o_serial_data_out <= load_byte[7]; // [RULE5]
         end
         else
         begin
            shreg_q           <= {shreg_q[6:0], 1'b0}; // [RULE6]
            o_serial_data_out <= shreg_q[6]; // [RULE5]
         end
         if (fmt_alt)
         begin
            o_channel_select_out <= (next_bit <= LEFT_LSB_BIT); // [RULE11] [RULE12]
         end
         else
         begin
            o_channel_select_out <= (next_bit >= LEFT_LSB_BIT) && (next_bit <= RIGHT_ENDWS); // [RULE9] [RULE10]
         end
      end
      else if (tick)
      begin
         o_serial_bit_clock_out <= 1'b1; // [RULE3]
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   idle_pins_a: assert property (!run |=> !o_serial_bit_clock_out && !o_serial_data_out // [RULE4]
      && o_channel_select_out) else $error("idle pins not steady");
   req_raise_a: assert property (!req_q && fifo_level == '0 && dma_ctl_q[DMA_CTL_EN_BIT] // [RULE1]
      |=> req_q) else $error("refill request not raised");
   req_hold_a: assert property (req_q && !(accept && fill_q == LAST_BYTE) |=> req_q) // [RULE17]
      else $error("refill request dropped early");
   req_full_a: assert property ($fell(req_q) |-> fifo_level == LW'(FIFO_WORDS)) // [RULE17]
      else $error("request ended before fifo full");
   shift_msb_a: assert property (fall_act && !take && started_q // [RULE5]
      |=> o_serial_data_out == $past(shreg_q[6])) else $error("bit order wrong");
   data_edge_a: assert property (run && $changed(o_serial_data_out) // [RULE13]
      |-> !o_serial_bit_clock_out) else $error("data moved off the falling edge");
   normal_ws_a: assert property (run && started_q && !fmt_alt && bit_q == 5'h10 // [RULE10]
      |-> o_channel_select_out) else $error("normal select low on right word");
   alt_ws_a: assert property (run && started_q && fmt_alt && $changed(bit_q) // [RULE12]
      && bit_q == FIRST_BIT |-> o_channel_select_out) else $error("alternate select not high at left msb");
   ws_lsb_a: assert property (run && !fmt_alt && $changed(bit_q) && bit_q == LEFT_LSB_BIT // [RULE9]
      |-> $rose(o_channel_select_out)) else $error("normal select late");
   restart_a: assert property ($rose(run) |-> bit_q == LAST_BIT && !started_q) // [RULE18]
      else $error("restart not at sample boundary");
   byte_pop_a: assert property (fifo_rd_ready |=> byte_idx_q == '0 // [RULE2]
      && latch_q == $past(fifo_rd_data[WORD_BITS-1 -: 8])) else $error("top byte not latched");

   run_c: cover property ($rose(run));
   normal_ws_c: cover property (run && !fmt_alt && $fell(o_channel_select_out));
   alt_ws_c: cover property (run && fmt_alt && $fell(o_channel_select_out));
   refill_c: cover property ($fell(req_q));
endmodule : serial_sound_output

// ---- test/dac_model.sv ----
// Behavioural serial-input audio converter that captures the three-wire stereo stream.
`timescale 1ns/10ps
module dac_model (
   input  wire logic i_bclk,
   input  wire logic i_data,
   input  wire logic i_ws
);
   logic    data_q[$];
   logic    ws_q[$];
   realtime t_rise = 0;
   realtime t_chg  = 0;
   realtime period = 0;
   int      n_bad  = 0;

   // Bits are taken on the rising bit clock edge.
   always @(posedge i_bclk)
   begin
      if (t_rise > 0)
         period = $realtime - t_rise;
      t_rise = $realtime;
      data_q.push_back(i_data);
      ws_q.push_back(i_ws);
   end

   always @(i_data or i_ws)
      t_chg = $realtime;

   // A change with the rise or while high would race the sampling edge, so it is counted.
   always @(negedge i_bclk)
      if (t_rise > 0 && t_chg >= t_rise && t_chg < $realtime)
         n_bad++;
endmodule : dac_model

// ---- test/testbench.sv ----
// Self-checking bench for the serial sound output: registers, DMA refill and stream formats.
`timescale 1ns/10ps
module testbench
   import sound_pkg::*;
;
   logic        clk = 0, rst = 1, wr = 0, rd = 0, rvalid, ext_clk = 0;
   logic [8:0]  addr = '0;
   logic [31:0] wdata = '0, rdata, dma_addr, dma_data = '0, rv;
   logic [2:0]  sound_ctl = '0;
   logic [7:0]  sound_freq = 8'h01;
   logic        dma_req, dma_valid = 0, dma_ready, dma_on = 0, bclk, sdata, ws;
   int          n_errors = 0;
   int          n_checks = 0;
   int          widx     = 0;
   int          cyc      = 0;

   localparam logic [8:0] RW_ADDR [6] = '{OFS_DISPLAY_MUX_CONTROL, OFS_SOUND_DMA_CURRENT_A,
      OFS_SOUND_DMA_END_A, OFS_SOUND_DMA_CURRENT_B, OFS_SOUND_DMA_END_B, OFS_SOUND_DMA_CONTROL};
   localparam bit RW_WIDE [6] = '{0, 1, 1, 1, 1, 0};

   initial
   begin
      forever #10 clk = ~clk;
   end

   // The sound clock runs at an eighth of the system clock rate, its edges 3 ns before a system clock rise.
   initial
   begin
      #7;
      forever #80 ext_clk = ~ext_clk;
   end

   serial_sound_output dut (
      .i_clk_sys(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .i_sound_ctl(sound_ctl), .i_sound_freq(sound_freq), .i_ext_sound_clk(ext_clk),
      .o_dma_req(dma_req), .o_dma_addr(dma_addr), .i_dma_valid(dma_valid),
      .o_dma_ready(dma_ready), .i_dma_data(dma_data), .o_serial_bit_clock_out(bclk),
      .o_serial_data_out(sdata), .o_channel_select_out(ws));

   dac_model dac (.i_bclk(bclk), .i_data(sdata), .i_ws(ws));

   function automatic logic [7:0] byte_of(input int b);
      return 8'(b * 37 + 11);
   endfunction : byte_of

   function automatic logic [31:0] pat(input int i);
      return 32'hA5C3_9600 + 32'(16 * (i + 1));
   endfunction : pat

   // Memory side: every third cycle stalls, and an offered word is held until taken.
   always @(posedge clk)
   begin
      if (dma_req && dma_valid && dma_ready)
         widx++;
      cyc++;
      if (!dma_valid || !dma_on || (dma_req && dma_ready))
      begin
         dma_valid <= dma_on && (cyc % 3 != 0);
         dma_data  <= {byte_of(4*widx+3), byte_of(4*widx+2), byte_of(4*widx+1), byte_of(4*widx)};
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("Checks %0d, errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   task automatic give_up(input string what);
      n_errors++;
      $display("CHECK FAILED at %0t: timeout on %s", $time, what);
      summarize();
   endtask : give_up

   task automatic do_reset();
      dma_on <= 0;
      rst    <= 1;
      repeat (6) @(posedge clk);
      rst  <= 0;
      widx = 0;
   endtask : do_reset

   task automatic reg_wr(input logic [8:0] a, input logic [31:0] d);
      @(posedge clk);
      wr    <= 1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 0;
   endtask : reg_wr

   task automatic reg_rd(input logic [8:0] a, output logic [31:0] d);
      @(posedge clk);
      rd   <= 1;
      addr <= a;
      @(posedge clk);
      rd <= 0;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         if (rvalid === 1'b1)
         begin
            d = rdata;
            return;
         end
      end
      give_up("read");
   endtask : reg_rd

   task automatic wait_req(input logic lvl);
      for (int i = 0; i < 100; i++)
      begin
         @(posedge clk);
         if (dma_req === lvl)
            return;
      end
      give_up("request");
   endtask : wait_req

   // Fill from memory, run the link for ns samples, stop it and compare what the receiver got.
   task automatic stream(input bit alt, input logic [1:0] run, input logic sel,
                         input logic [7:0] f, input int ns, input int per);
      logic [31:0] d;
      logic [31:0] w;
      int          k;
      do_reset();
      dma_on <= 1;
      reg_wr(OFS_DISPLAY_MUX_CONTROL, {31'h0, alt});
      reg_wr(OFS_SOUND_DMA_CURRENT_A, 32'h0000_2000);
      reg_wr(OFS_SOUND_DMA_CONTROL, 32'h1);
      wait_req(1'b1);
      wait_req(1'b0);
      check(dma_addr, 32'h0000_2010, "refill address");
      check(32'(widx), 32'h4, "words per refill");
      reg_rd(OFS_SOUND_DMA_STATE, d);
      check(d, 32'h0000_0014, "state after refill");
      dac.data_q.delete();
      dac.ws_q.delete();
      sound_ctl  <= {run, sel};
      sound_freq <= f;
      for (k = 0; k < 20000 && dac.data_q.size() < ns * 32; k++)
         @(posedge clk);
      if (k == 20000)
         give_up("serial bits");
      sound_ctl <= 3'h0;
      repeat (4) @(posedge clk);
      check({bclk, sdata, ws}, 32'h1, "idle after stop");
      check(32'(dac.n_bad), 32'h0, "data moved off the falling edge");
      check(32'(int'(dac.period)), 32'(per), "bit period");
      for (int s = 0; s < ns; s++)
      begin
         for (int b = 0; b < 32; b++)
         begin
            d[31-b] = dac.data_q[s*32+b];
            w[31-b] = dac.ws_q[s*32+b];
         end
         check(d, {byte_of(4*s), byte_of(4*s+1), byte_of(4*s+2), byte_of(4*s+3)},
               "sample data");
         check(w, alt ? 32'hFFFF_0000 : 32'h0001_FFFE,
               "word select");
      end
      $display("test stream done, alternate %0d", alt);
   endtask : stream

   initial
   begin
      do_reset();
      check({bclk, sdata, ws}, 32'h1, "idle pins after reset");
      check(dma_req, 32'h0, "request after reset");
      for (int i = 0; i < 6; i++)
      begin
         reg_rd(RW_ADDR[i], rv);
         check(rv, 32'h0, "reset value");
         reg_wr(RW_ADDR[i], pat(i));
      end
      for (int i = 0; i < 6; i++)
      begin
         reg_rd(RW_ADDR[i], rv);
         check(rv, pat(i) & (RW_WIDE[i] ? 32'hFFFF_FFFF : 32'h0000_00FF), "read back");
      end
      check(dma_addr, pat(1), "address follows current pointer");
      check(dma_req, 32'h0, "no request while disabled");
      reg_wr(OFS_SOUND_DMA_STATE, 32'h0000_00FF);
      reg_rd(OFS_SOUND_DMA_STATE, rv);
      check(rv, 32'h0, "status is read only");
      reg_wr(9'h000, 32'hFFFF_FFFF);
      reg_rd(9'h000, rv);
      check(rv, 32'h0, "unmapped read");
      $display("test registers done");
      stream(1'b0, 2'b01, 1'b1, 8'h01, 6, 80);
      stream(1'b1, 2'b10, 1'b1, 8'h02, 6, 160);
      stream(1'b0, 2'b11, 1'b0, 8'h02, 2, 1280);
      stream(1'b1, 2'b11, 1'b1, 8'h00, 1, 40);
      summarize();
   end
endmodule : testbench
